/* inc/serial_port_defines.vh */
// Constants for the two-wire slave port engine
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
`define CTL_MODE_MSB 3
`define CTL_MODE_LSB 0
`define CTL_RELEASE 4
`define CTL_ENABLE 5
`define CTL_OVERFLOW 6
`define STA_FULL 0
`define STA_UPDATE 1
`define STA_READ 2
`define STA_START 3
`define STA_STOP 4
`define STA_DATA 5
`define MODE_SLAVE7 4'h6
`define MODE_SLAVE10 4'h7
`define MODE_MASTER 4'h8
`define CTL_RESET 8'h00
`define BYTE_BITS 4'h8
`define ACK_BIT 4'h9
`define TENBIT_HEAD 5'h1e
`endif

/* src/line_sync.v */
// Two-stage synchroniser with edge detection for one bus line
`include "serial_port_defines.vh"
module line_sync (
    input wire clk,
    input wire rst_n,
    input wire line_in,
    output reg level,
    output wire rise,
    output wire fall
);
    reg meta_reg;
    reg sync_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            level <= 1'b1;
        end else begin
            meta_reg <= line_in;
            sync_reg <= meta_reg;
            level <= sync_reg;
        end
    end
    // Edges judged only after the second stage
    assign rise = sync_reg & ~level;
    assign fall = ~sync_reg & level;
endmodule

/* src/addr_match.v */
// Address comparison for 7-bit and 10-bit slave addressing
`include "serial_port_defines.vh"
module addr_match (
    input wire [7:0] shift_byte,
    input wire [7:0] own_addr,
    input wire ten_bit,
    input wire first_byte,
    input wire second_expected,
    output wire hit,
    output wire head_ok
);
    function is_head;
        input [7:0] b;
        begin
            is_head = (b[7:3] == `TENBIT_HEAD);
        end
    endfunction
    assign head_ok = is_head(shift_byte);
    // bits seven to one against the own address; all eight bits for the expected second byte
    assign hit = second_expected ? (shift_byte == own_addr) :
        (first_byte & (shift_byte[7:1] == own_addr[7:1]) &
        (~ten_bit | is_head(shift_byte)));
endmodule

/* src/port_slave_engine.v */
// Two-wire slave engine: START/STOP, address, receive and transmit
`include "serial_port_defines.vh"
// Function
// - Port and pins active only while the enable bit is set.
// - Four-bit mode field picks 7-bit or 10-bit slave; master and other values idle the engine.
// - Status reports start, stop, data/address, update-needed and direction.
// - Shift register and buffer double buffer; completed byte sets flag.
// - Byte completing with buffer full sets overflow and is lost.
// - After START, shift eight bits sampled on rising clock.
// - Compare shift bits seven to one with own address.
// - On match, load and set full at 8th fall, flag at 9th.
// - Automatic acknowledge after address or data, buffer loaded.
// - Flag always set; load follows full, acknowledge follows full and overflow.
// - Byte with full set keeps buffer, sets flag and overflow.
// - Buffer read clears full; overflow held until software clears.
// - 10-bit head byte is 11110, A9, A8, write.
// - 10-bit address byte stretches clock until own address written.
// - After repeated START in 10-bit, first byte alone matches.
// - Write address clears direction and is placed into buffer.
// - Flag once per byte, held until software clears it.
// - Read address sets direction, loads buffer, acks, stretches clock.
// - Transmit shifts on falling edges, flag on ninth fall.
// - Master ack latched on ninth rise; no-ack resets slave logic.
module port_slave_engine (
    input wire CLK,
    input wire RST_N,
    input wire SCL_IN,
    output wire SCL_OUT,
    output wire SCL_OE_N,
    input wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OE_N,
    input wire PORT_ENABLE,
    input wire [3:0] PORT_MODE,
    input wire CLOCK_RELEASE_SET,
    input wire OVERFLOW_CLEAR,
    input wire FLAG_CLEAR,
    input wire ADDR_WRITE,
    input wire [7:0] ADDR_WDATA,
    input wire BUF_WRITE,
    input wire [7:0] BUF_WDATA,
    input wire BUF_READ,
    output reg [7:0] TRANSFER_BUFFER,
    output reg [7:0] OWN_ADDRESS,
    output wire [7:0] PORT_CONTROL,
    output wire [7:0] PORT_STATUS,
    output reg PORT_INTERRUPT_FLAG
);
    localparam ST_IDLE = 3'd0;
    localparam ST_RX = 3'd1;
    localparam ST_ACK = 3'd2;
    localparam ST_STRETCH = 3'd3;
    localparam ST_TX = 3'd4;
    localparam ST_TXACK = 3'd5;

    wire scl;
    wire scl_rise;
    wire scl_fall;
    wire sda;
    wire sda_rise;
    wire sda_fall;
    wire hit;
    wire head_ok;
    reg [2:0] state_reg;
    reg [7:0] shift_reg;
    reg [3:0] bit_cnt_reg;
    reg full_reg;
    reg overflow_reg;
    reg update_reg;
    reg read_reg;
    reg start_reg;
    reg stop_reg;
    reg data_reg;
    reg release_reg;
    reg ack_drive_reg;
    reg sda_low_reg;
    reg addressed_reg;
    reg first_reg;
    reg second_reg;
    reg head_seen_reg;
    reg accept_reg;
    reg [7:0] mode_reg;

    wire active = PORT_ENABLE;
    wire slave_mode = (PORT_MODE == `MODE_SLAVE7) |
        (PORT_MODE == `MODE_SLAVE10);
    wire ten_bit = (PORT_MODE == `MODE_SLAVE10);
    wire run = active & slave_mode;
    wire start_ev = run & sda_fall & scl;
    wire stop_ev = run & sda_rise & scl;

    line_sync scl_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .line_in(SCL_IN),
        .level(scl),
        .rise(scl_rise),
        .fall(scl_fall)
    );
    line_sync sda_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .line_in(SDA_IN),
        .level(sda),
        .rise(sda_rise),
        .fall(sda_fall)
    );
    addr_match matcher (
        .shift_byte(shift_reg),
        .own_addr(OWN_ADDRESS),
        .ten_bit(ten_bit),
        .first_byte(first_reg),
        .second_expected(second_reg),
        .hit(hit),
        .head_ok(head_ok)
    );

    assign PORT_CONTROL = {1'b0, overflow_reg, PORT_ENABLE, release_reg,
        PORT_MODE};
    assign PORT_STATUS = {2'b00, data_reg, stop_reg, start_reg, read_reg,
        update_reg, full_reg};
    // Pins only driven low; open drain, released when disabled
    assign SDA_OUT = 1'b0;
    assign SCL_OUT = 1'b0;
    assign SDA_OE_N = ~(run & sda_low_reg);
    assign SCL_OE_N = ~(run & ~release_reg);

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            full_reg <= 1'b0;
            overflow_reg <= 1'b0;
            update_reg <= 1'b0;
            read_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            data_reg <= 1'b0;
            release_reg <= 1'b1;
            ack_drive_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            addressed_reg <= 1'b0;
            first_reg <= 1'b0;
            second_reg <= 1'b0;
            head_seen_reg <= 1'b0;
            accept_reg <= 1'b0;
            TRANSFER_BUFFER <= 8'h00;
            OWN_ADDRESS <= 8'h00;
            PORT_INTERRUPT_FLAG <= 1'b0;
            mode_reg <= `CTL_RESET;
        end else begin
            mode_reg <= {4'h0, PORT_MODE};
            // Software side; hardware sets below take priority
            if (FLAG_CLEAR)
                PORT_INTERRUPT_FLAG <= 1'b0;
            if (OVERFLOW_CLEAR)
                overflow_reg <= 1'b0;
            if (BUF_READ)
                full_reg <= 1'b0;
            if (ADDR_WRITE) begin
                OWN_ADDRESS <= ADDR_WDATA;
                if (update_reg) begin
                    update_reg <= 1'b0;
                    release_reg <= 1'b1;
                end
            end
            if (BUF_WRITE) begin
                TRANSFER_BUFFER <= BUF_WDATA;
                shift_reg <= BUF_WDATA;
            end
            if (CLOCK_RELEASE_SET)
                release_reg <= 1'b1;
            if (!run) begin
                // Disabled port: state machine, addressing and bus flags idle
                state_reg <= ST_IDLE;
                start_reg <= 1'b0;
                stop_reg <= 1'b0;
                sda_low_reg <= 1'b0;
                release_reg <= 1'b1;
                addressed_reg <= 1'b0;
                second_reg <= 1'b0;
                head_seen_reg <= 1'b0;
            end else if (start_ev) begin
                start_reg <= 1'b1;
                stop_reg <= 1'b0;
                state_reg <= ST_RX;
                bit_cnt_reg <= 4'h0;
                first_reg <= 1'b1;
                sda_low_reg <= 1'b0;
                addressed_reg <= 1'b0;
                second_reg <= 1'b0;
                // Head seen earlier lets a repeated START skip byte two
                head_seen_reg <= head_seen_reg & ten_bit;
            end else if (stop_ev) begin
                stop_reg <= 1'b1;
                start_reg <= 1'b0;
                state_reg <= ST_IDLE;
                sda_low_reg <= 1'b0;
                addressed_reg <= 1'b0;
                head_seen_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        sda_low_reg <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_fall && bit_cnt_reg == `BYTE_BITS) begin
                            if (addressed_reg) begin
                                accept_reg <= ~full_reg & ~overflow_reg;
                                if (!full_reg) begin
                                    TRANSFER_BUFFER <= shift_reg;
                                    full_reg <= 1'b1;
                                end else
                                    overflow_reg <= 1'b1;
                                data_reg <= 1'b1;
                                sda_low_reg <= ~full_reg &
                                    ~overflow_reg;
                                state_reg <= ST_ACK;
                            end else if (hit) begin
                                // Full buffer keeps its old contents
                                if (!full_reg)
                                    TRANSFER_BUFFER <= shift_reg;
                                full_reg <= 1'b1;
                                accept_reg <= ~full_reg & ~overflow_reg;
                                sda_low_reg <= ~full_reg &
                                    ~overflow_reg;
                                if (full_reg)
                                    overflow_reg <= 1'b1;
                                data_reg <= 1'b0;
                                if (first_reg)
                                    read_reg <= shift_reg[0];
                                if (ten_bit && first_reg &&
                                    !head_seen_reg && !shift_reg[0]) begin
                                    update_reg <= 1'b1;
                                    head_seen_reg <= head_ok;
                                    second_reg <= 1'b1;
                                end else if (second_reg) begin
                                    update_reg <= 1'b1;
                                    second_reg <= 1'b0;
                                    addressed_reg <= 1'b1;
                                end else
                                    addressed_reg <= 1'b1;
                                first_reg <= 1'b0;
                                state_reg <= ST_ACK;
                            end else begin
                                // Not for us: ignore until next START
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_low_reg <= 1'b0;
                            PORT_INTERRUPT_FLAG <= 1'b1;
                            bit_cnt_reg <= 4'h0;
                            if (addressed_reg && read_reg) begin
                                release_reg <= 1'b0;
                                state_reg <= ST_STRETCH;
                            end else begin
                                // Stretch after ack while the own address update is pending
                                if (update_reg)
                                    release_reg <= 1'b0;
                                state_reg <= ST_RX;
                            end
                        end
                    end
                    ST_STRETCH: begin
                        // Clock held low until software releases it
                        if (release_reg) begin
                            sda_low_reg <= ~shift_reg[7];
                            state_reg <= ST_TX;
                        end
                    end
                    ST_TX: begin
                        if (scl_rise)
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (scl_fall) begin
                            if (bit_cnt_reg == `BYTE_BITS) begin
                                sda_low_reg <= 1'b0;
                                state_reg <= ST_TXACK;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_low_reg <= ~shift_reg[6];
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            // Latched no-ack, acted on at ninth fall
                            ack_drive_reg <= sda;
                            bit_cnt_reg <= `ACK_BIT;
                        end
                        if (scl_fall && bit_cnt_reg == `ACK_BIT) begin
                            PORT_INTERRUPT_FLAG <= 1'b1;
                            data_reg <= 1'b1;
                            bit_cnt_reg <= 4'h0;
                            if (ack_drive_reg) begin
                                state_reg <= ST_IDLE;
                                addressed_reg <= 1'b0;
                            end else begin
                                release_reg <= 1'b0;
                                state_reg <= ST_STRETCH;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* bench/bus_master_model.sv */
// Behavioural two-wire bus master on open-drain lines
module bus_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Slave may stretch, so never go on before the line is high
    task automatic let_scl();
        scl_low = 1'b0;
        wait (scl === 1'b1);
    endtask
    task automatic start();
        sda_low = 1'b0;
        #200 let_scl();
        #200 sda_low = 1'b1;
        #200 scl_low = 1'b1;
    endtask
    task automatic stop();
        #100 sda_low = 1'b1;
        #200 let_scl();
        #200 sda_low = 1'b0;
        #400;
    endtask
    // Long low phase leaves the slave time to change data before rise
    task automatic bit_io(input logic b, output logic q);
        #100 sda_low = ~b;
        #500 let_scl();
        #100 q = sda;
        #100 scl_low = 1'b1;
    endtask
    // Ninth bit: mack high releases the line to read the slave's ack
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q);
            r[i] = q;
        end
        bit_io(mack, ack);
    endtask
endmodule

/* bench/port_slave_engine_chk.sv */
// Concurrent checks on the slave port engine's pins and flags
module port_slave_engine_chk (
    input wire CLK,
    input wire RST_N,
    input wire SCL_IN,
    input wire SDA_IN,
    input wire SCL_OE_N,
    input wire SDA_OE_N,
    input wire PORT_ENABLE,
    input wire [3:0] PORT_MODE,
    input wire CLOCK_RELEASE_SET,
    input wire OVERFLOW_CLEAR,
    input wire FLAG_CLEAR,
    input wire ADDR_WRITE,
    input wire BUF_WRITE,
    input wire [7:0] TRANSFER_BUFFER,
    input wire [7:0] PORT_CONTROL,
    input wire [7:0] PORT_STATUS,
    input wire PORT_INTERRUPT_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence start_seen; SCL_IN && $fell(SDA_IN); endsequence
    sequence stop_seen; SCL_IN && $rose(SDA_IN); endsequence
    a_pins_released: assert property (
        (!PORT_ENABLE || PORT_MODE == 4'h8)[*2] |-> SCL_OE_N && SDA_OE_N)
        else $error("bus lines driven while port idle");
    a_start_flagged: assert property (
        start_seen ##0 PORT_ENABLE && PORT_MODE != 4'h8
        |-> ##[1:6] PORT_STATUS[3]) else $error("start not reported");
    a_stop_flagged: assert property (
        stop_seen ##0 PORT_ENABLE && PORT_MODE != 4'h8
        |-> ##[1:6] PORT_STATUS[4]) else $error("stop not reported");
    a_flag_holds: assert property (
        PORT_INTERRUPT_FLAG && !FLAG_CLEAR && !$past(FLAG_CLEAR)
        |=> PORT_INTERRUPT_FLAG) else $error("flag dropped by itself");
    a_overflow_holds: assert property (
        PORT_CONTROL[6] && !OVERFLOW_CLEAR && !$past(OVERFLOW_CLEAR)
        |=> PORT_CONTROL[6]) else $error("overflow dropped by itself");
    a_load_sets_full: assert property (
        $changed(TRANSFER_BUFFER) && !$past(BUF_WRITE)
        && !$past(BUF_WRITE, 2) |-> PORT_STATUS[0])
        else $error("buffer loaded without full flag");
    a_overflow_keeps: assert property (
        $rose(PORT_CONTROL[6]) |-> $stable(TRANSFER_BUFFER))
        else $error("overflowing byte reached the buffer");
    a_no_ack_overflow: assert property (
        PORT_CONTROL[6] && $past(PORT_CONTROL[6]) && !PORT_STATUS[2]
        |-> SDA_OE_N) else $error("ack driven during overflow");
    a_stretch_holds: assert property (
        !SCL_OE_N && !CLOCK_RELEASE_SET && !ADDR_WRITE
        && !$past(CLOCK_RELEASE_SET) && !$past(ADDR_WRITE) |=> !SCL_OE_N)
        else $error("clock released without software");
endmodule
bind port_slave_engine port_slave_engine_chk u_port_slave_engine_chk (
    .CLK(CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N), .PORT_ENABLE(PORT_ENABLE),
    .PORT_MODE(PORT_MODE), .CLOCK_RELEASE_SET(CLOCK_RELEASE_SET),
    .OVERFLOW_CLEAR(OVERFLOW_CLEAR), .FLAG_CLEAR(FLAG_CLEAR),
    .ADDR_WRITE(ADDR_WRITE), .BUF_WRITE(BUF_WRITE),
    .TRANSFER_BUFFER(TRANSFER_BUFFER), .PORT_CONTROL(PORT_CONTROL),
    .PORT_STATUS(PORT_STATUS), .PORT_INTERRUPT_FLAG(PORT_INTERRUPT_FLAG)
);

/* bench/tb.sv */
// Self-checking bench for the two-wire slave port engine
`include "serial_port_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, enable, rel_set, ov_clr, flag_clr, addr_wr;
    logic buf_wr, buf_rd, m_scl_low, m_sda_low, flag, ack;
    logic scl_oe_n, sda_oe_n;
    logic [3:0] mode;
    logic [7:0] addr_d, buf_d, tbuf, oaddr, ctl, sta, r;
    int errors, samples_checked;
    // Pull-ups: a released line reads high
    wire scl = !(m_scl_low || !scl_oe_n);
    wire sda = !(m_sda_low || !sda_oe_n);
    port_slave_engine u_port_slave_engine (
        .CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SCL_OUT(),
        .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(),
        .SDA_OE_N(sda_oe_n), .PORT_ENABLE(enable), .PORT_MODE(mode),
        .CLOCK_RELEASE_SET(rel_set), .OVERFLOW_CLEAR(ov_clr),
        .FLAG_CLEAR(flag_clr), .ADDR_WRITE(addr_wr), .ADDR_WDATA(addr_d),
        .BUF_WRITE(buf_wr), .BUF_WDATA(buf_d), .BUF_READ(buf_rd),
        .TRANSFER_BUFFER(tbuf), .OWN_ADDRESS(oaddr), .PORT_CONTROL(ctl),
        .PORT_STATUS(sta), .PORT_INTERRUPT_FLAG(flag)
    );
    bus_master_model u_bus_master_model (.scl(scl), .sda(sda),
        .scl_low(m_scl_low), .sda_low(m_sda_low));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Software strobe: 0 read, 1 flag clr, 2 ovf clr, 3 addr, 4 buf, 5 rel
    task automatic sw(input int op, input logic [7:0] d);
        @(negedge clk);
        addr_d = d;
        buf_d = d;
        case (op)
            0: buf_rd = 1'b1;
            1: flag_clr = 1'b1;
            2: ov_clr = 1'b1;
            3: addr_wr = 1'b1;
            4: buf_wr = 1'b1;
            5: rel_set = 1'b1;
        endcase
        @(negedge clk);
        {buf_rd, flag_clr, ov_clr, addr_wr, buf_wr, rel_set} = 6'h00;
        repeat (2) @(negedge clk);
    endtask
    task automatic service();
        sw(0, 8'h00);
        sw(1, 8'h00);
        chk({7'h00, flag}, 8'h00);
        chk(sta & 8'h01, 8'h00);
    endtask
    // Flags settle a few clocks after the ninth falling edge
    task automatic byte_io(input logic [7:0] d, input logic mack);
        u_bus_master_model.xfer(d, mack, r, ack);
        repeat (6) @(negedge clk);
    endtask
    task automatic rx(input logic [7:0] d, input logic a,
                      input logic [7:0] b, input logic [7:0] s);
        byte_io(d, 1'b1);
        chk({7'h00, ack}, {7'h00, a});
        chk(tbuf, b);
        chk(sta, s);
        chk({7'h00, flag}, 8'h01);
    endtask
    task automatic send_back(input logic [7:0] d, input logic mack);
        sw(4, d);
        sw(5, 8'h00);
        byte_io(8'hff, mack);
        chk(r, d);
        chk({7'h00, flag}, 8'h01);
        service();
    endtask
    // Bound set well past the roughly 150 microseconds of traffic
    initial begin
        #4000000;
        errors++;
        summarize();
    end
    initial begin
        {rst_n, enable, rel_set, ov_clr, flag_clr, addr_wr} = 6'h00;
        {buf_wr, buf_rd} = 2'b00;
        mode = `MODE_SLAVE7;
        {addr_d, buf_d} = 16'h0000;
        errors = 0;
        samples_checked = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(sta, 8'h00);
        chk(ctl & 8'h50, 8'h10);
        sw(3, 8'h84);
        chk(oaddr, 8'h84);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            enable = (i == 1);
            mode = (i == 1) ? `MODE_MASTER : `MODE_SLAVE7;
            u_bus_master_model.start();
            byte_io(8'h84, 1'b1);
            chk({7'h00, ack, flag}, 8'h02);
            u_bus_master_model.stop();
        end
        @(negedge clk);
        mode = `MODE_SLAVE7;
        u_bus_master_model.start();
        rx(8'h84, 1'b0, 8'h84, 8'h09);
        service();
        rx(8'h5a, 1'b0, 8'h5a, 8'h29);
        sw(1, 8'h00);
        rx(8'ha5, 1'b1, 8'h5a, 8'h29);
        sw(0, 8'h00);
        chk(ctl & 8'h40, 8'h40);
        sw(1, 8'h00);
        rx(8'h3c, 1'b1, 8'h3c, 8'h29);
        sw(2, 8'h00);
        chk(ctl & 8'h40, 8'h00);
        service();
        rx(8'h11, 1'b0, 8'h11, 8'h29);
        service();
        u_bus_master_model.stop();
        chk(sta & 8'h18, 8'h10);
        u_bus_master_model.start();
        byte_io(8'h86, 1'b1);
        chk({7'h00, ack, flag}, 8'h02);
        chk(tbuf, 8'h11);
        u_bus_master_model.start();
        rx(8'h85, 1'b0, 8'h85, 8'h0d);
        chk({7'h00, scl_oe_n}, 8'h00);
        service();
        send_back(8'hc3, 1'b0);
        chk({7'h00, scl_oe_n}, 8'h00);
        send_back(8'h96, 1'b1);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        u_bus_master_model.stop();
        @(negedge clk);
        mode = `MODE_SLAVE10;
        sw(3, 8'hf2);
        u_bus_master_model.start();
        rx(8'hf2, 1'b0, 8'hf2, 8'h0b);
        chk({7'h00, scl_oe_n}, 8'h00);
        sw(3, 8'h34);
        chk({6'h00, sta[1], scl_oe_n}, 8'h01);
        service();
        rx(8'h34, 1'b0, 8'h34, 8'h0b);
        sw(3, 8'hf2);
        service();
        rx(8'h77, 1'b0, 8'h77, 8'h29);
        service();
        u_bus_master_model.start();
        rx(8'hf3, 1'b0, 8'hf3, 8'h0d);
        service();
        send_back(8'h0f, 1'b1);
        u_bus_master_model.stop();
        summarize();
    end
endmodule
